// ==== design/bas_seq.sv ====
// Purpose: Word-address sequencer for linear, wrapped and hybrid bursts.
// Assumes: cs_n, cmd_load, command_address_word and word_adv are synchronous to link_clk.
// Notes:   Configuration is written on sys_clk and crosses to link_clk by a toggle handshake.
// Notes on behaviour
// - Wrapped bursts stay inside one aligned group of 16, 32, 64 or 128 bytes.
// - Wrapped burst starts at given word, climbs to group end, wraps to group start.
// - Hybrid mode completes exactly one wrap through the group, then leaves it.
// - After the hybrid wrap, addresses increase linearly until chip select goes high.
// - Linear phase of hybrid starts at first word of the following group.
// - Config bit 2 picks hybrid when 0, legacy wrap when 1; resets to 1.
// - Low three config bits decode hybrid or wrap with lengths 128, 64, 16, 32.
// - Burst-type bit 1 forces a linear burst; 0 uses the configured wrap mode.
// - Sequences count 16-bit words; a group holds half its byte length in words.
// - Group-length field resets to 32 bytes; 00=128, 01=64, 10=16, 11=32.
`include "bas_seq_cfg.svh"
module bas_seq
    import bas_seq_pkg::*;
#(
    parameter int AW = `BAS_ADDR_W
) (
    input  wire logic          sys_clk,              // Configuration clock.
    input  wire logic          rst,                  // Asynchronous reset, active high.
    input  wire logic          cfg_wr,               // Load pulse for the burst config.
    input  wire logic [2:0]    cfg_wdata,            // New wrap_mode_field value.
    output      bas_cfg_t      burst_config_register, // Current config, sys_clk side.
    output      logic          cfg_busy,             // Crossing of a config write pending.
    input  wire logic          link_clk,             // Bus clock from the controller.
    input  wire logic          cs_n,                 // Chip select, active low.
    input  wire logic          cmd_load,             // Command-address word is valid.
    input  wire logic [47:0]   command_address_word, // Captured command-address.
    input  wire logic          word_adv,             // One data word transferred.
    output      logic [AW-1:0] word_addr,            // Current word address.
    output      logic          burst_active          // A burst is in progress.
);
    bas_cfg_t   cfg_reg;
    logic       wr_tog_reg;
    logic [1:0] ack_sync_reg;
    logic       cfg_seen_reg;
    logic [1:0] link_rst_reg;
    logic       link_rst;
    logic [2:0] tog_sync_reg;
    bas_cfg_t   cfg_link_reg;
    bas_state_t state_reg;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] base_reg;
    logic [5:0] mask_reg;
    logic [5:0] start_lo_reg;
    logic       hybrid_reg;
    logic [5:0] mask_next;
    logic [31:0] start_full;
    logic [AW-1:0] start_addr;
    logic [5:0] lo_inc;
    logic [AW-1:0] wrap_next;
    logic [AW-1:0] grp_next;
    logic       wrap_done;
    logic [1:0] sys_rst_reg;
    logic       sys_rst;

    // The release of rst is retimed, so no sys_clk flop leaves reset close to an edge.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sys_rst_reg <= 2'h3;
        end else begin
            sys_rst_reg <= {sys_rst_reg[0], 1'b0};
        end
    end
    assign sys_rst = sys_rst_reg[1];

    // Sys side: hold the value stable and toggle; the link side picks it up.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg    <= `BAS_CFG_RESET;
            wr_tog_reg <= 1'b0;
        end else if (cfg_wr && !cfg_busy) begin
            cfg_reg    <= cfg_wdata;
            wr_tog_reg <= ~wr_tog_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_sync_reg <= 2'h0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], tog_sync_reg[2]};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_seen_reg <= 1'b0;
        end else if (cfg_wr) begin
            cfg_seen_reg <= 1'b1;
        end
    end

    // A write is refused until the previous one has been seen by the link domain.
    assign cfg_busy              = wr_tog_reg ^ ack_sync_reg[1];
    assign burst_config_register = cfg_reg;

    cfg_reset_val_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !cfg_seen_reg |-> (cfg_reg == `BAS_CFG_RESET))
        else $error("config left its reset value without a write");

    // Link reset: asserted at once, released on link_clk.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            link_rst_reg <= 2'h3;
        end else begin
            link_rst_reg <= {link_rst_reg[0], 1'b0};
        end
    end
    assign link_rst = link_rst_reg[1];

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            tog_sync_reg <= 3'h0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
        end
    end

    // The link clock may stop between frames, so a write lands on the third running edge after the toggle.
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            cfg_link_reg <= `BAS_CFG_RESET;
        end else if (tog_sync_reg[2] ^ tog_sync_reg[1]) begin
            cfg_link_reg <= cfg_reg;
        end
    end

    always_comb begin
        case (cfg_link_reg.group_len)
            `BAS_LEN_128: mask_next = `BAS_MASK_128;
            `BAS_LEN_64:  mask_next = `BAS_MASK_64;
            `BAS_LEN_16:  mask_next = `BAS_MASK_16;
            default:      mask_next = `BAS_MASK_32;
        endcase
    end

    assign start_full = {command_address_word[`BAS_UPPER_HI:`BAS_UPPER_LO],
                         command_address_word[`BAS_LOWER_HI:0]};
    assign start_addr = start_full[AW-1:0];
    assign lo_inc     = addr_reg[5:0] + 6'h01;
    assign wrap_next  = {addr_reg[AW-1:6], (addr_reg[5:0] & ~mask_reg) | (lo_inc & mask_reg)};
    assign wrap_done  = (lo_inc & mask_reg) == (start_lo_reg & mask_reg);
    assign grp_next   = base_reg + AW'(mask_reg) + AW'(1);

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            state_reg <= BAS_IDLE;
        end else if (cs_n) begin
            state_reg <= BAS_IDLE;
        end else if (cmd_load) begin
            state_reg <= command_address_word[`BAS_BT_BIT] ? BAS_LINEAR : BAS_WRAP;
        end else if (state_reg == BAS_WRAP && word_adv && hybrid_reg && wrap_done) begin
            state_reg <= BAS_LINEAR;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            addr_reg <= '0;
        end else if (cmd_load && !cs_n) begin
            addr_reg <= start_addr;
        end else if (!cs_n && word_adv) begin
            case (state_reg)
                BAS_WRAP: begin
                    if (hybrid_reg && wrap_done) begin
                        addr_reg <= grp_next;
                    end else begin
                        addr_reg <= wrap_next;
                    end
                end
                BAS_LINEAR: addr_reg <= addr_reg + AW'(1);
                default:    addr_reg <= addr_reg;
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            base_reg     <= '0;
            mask_reg     <= `BAS_MASK_32;
            start_lo_reg <= 6'h00;
            hybrid_reg   <= 1'b0;
        end else if (cmd_load && !cs_n) begin
            base_reg     <= start_addr & ~AW'(mask_next);
            mask_reg     <= mask_next;
            start_lo_reg <= start_addr[5:0];
            hybrid_reg   <= ~cfg_link_reg.hybrid_wrap_select;
        end
    end

    assign word_addr    = addr_reg;
    assign burst_active = (state_reg != BAS_IDLE);

    group_inside_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_WRAP) |-> ((addr_reg & ~AW'(mask_reg)) == base_reg))
        else $error("wrapped address left its group");

    wrap_step_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_WRAP && !cs_n && !cmd_load && word_adv && !hybrid_reg)
        |=> (addr_reg == (((($past(addr_reg) & AW'($past(mask_reg))) == AW'($past(mask_reg)))
            ? $past(base_reg) : $past(addr_reg) + AW'(1)))))
        else $error("wrapped step is wrong");

    hybrid_exit_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_WRAP && !cs_n && !cmd_load && word_adv && hybrid_reg && wrap_done)
        |=> (state_reg == BAS_LINEAR))
        else $error("hybrid did not leave wrap after one pass");

    next_group_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_WRAP && !cs_n && !cmd_load && word_adv && hybrid_reg && wrap_done)
        |=> (addr_reg == $past(base_reg) + AW'($past(mask_reg)) + AW'(1)))
        else $error("hybrid linear phase starts at wrong word");

    linear_inc_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_LINEAR && !cs_n && !cmd_load && word_adv)
        ##1 (!cs_n && !cmd_load && word_adv)
        |=> (addr_reg == $past(addr_reg, 2) + AW'(2)))
        else $error("linear phase does not increment");

    type_bit_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (cmd_load && !cs_n) |=> (state_reg == ($past(command_address_word[`BAS_BT_BIT])
            ? BAS_LINEAR : BAS_WRAP)))
        else $error("burst type bit not honoured");

    mode_decode_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (cmd_load && !cs_n) |=> (hybrid_reg == !$past(cfg_link_reg.hybrid_wrap_select)))
        else $error("hybrid select decoded wrongly");

    half_words_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (cmd_load && !cs_n && cfg_link_reg.group_len == `BAS_LEN_16) |=> (mask_reg == 6'h07))
        else $error("16-byte group is not eight words");

    legacy_stay_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (state_reg == BAS_WRAP && !hybrid_reg && !cs_n && !cmd_load) |=> (state_reg == BAS_WRAP))
        else $error("legacy wrap left its group");

    start_load_a: assert property (@(posedge link_clk) disable iff (link_rst)
        (cmd_load && !cs_n) |=> (addr_reg == $past(start_addr)))
        else $error("start word not loaded");
endmodule

// ==== shared/bas_seq_cfg.svh ====
// Purpose: Constants of the burst address sequencer.
// Assumes: Included by the package and the design module.
// Notes:   Field positions refer to the command-address word and the burst config register.
`ifndef BAS_SEQ_CFG_SVH
`define BAS_SEQ_CFG_SVH
`define BAS_CFG_RESET   3'h7
`define BAS_HYB_BIT     2
`define BAS_BT_BIT      45
`define BAS_UPPER_HI    44
`define BAS_UPPER_LO    16
`define BAS_LOWER_HI    2
`define BAS_LEN_128     2'h0
`define BAS_LEN_64      2'h1
`define BAS_LEN_16      2'h2
`define BAS_LEN_32      2'h3
`define BAS_MASK_128    6'h3F
`define BAS_MASK_64     6'h1F
`define BAS_MASK_16     6'h07
`define BAS_MASK_32     6'h0F
`define BAS_ADDR_W      23
`endif

// ==== shared/bas_seq_pkg.sv ====
// Purpose: Types of the burst address sequencer.
// Assumes: Constants come from the cfg header.
// Notes:   None.
`include "bas_seq_cfg.svh"
package bas_seq_pkg;
    typedef struct packed {
        logic       hybrid_wrap_select;
        logic [1:0] group_len;
    } bas_cfg_t;
    typedef enum logic [1:0] {
        BAS_IDLE   = 2'h0,
        BAS_WRAP   = 2'h1,
        BAS_LINEAR = 2'h3
    } bas_state_t;
endpackage

// ==== verification/bas_host_model.sv ====
// Purpose: Host controller model that frames bursts on the link side.
// Assumes: All link signals change just after a rising edge of link_clk.
// Notes:   Keeps the address seen for each word so the bench can judge it.
module bas_host_model (
    input  wire logic        link_clk,             // Bus clock.
    input  wire logic [22:0] word_addr,            // Address from the sequencer.
    output      logic        cs_n,                 // Chip select, active low.
    output      logic        cmd_load,             // Command-address valid pulse.
    output      logic [47:0] command_address_word, // Command-address.
    output      logic        word_adv              // One data word per cycle.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] seen [0:69];
    initial begin
        cs_n = 1'b1;
        cmd_load = 1'b0;
        word_adv = 1'b0;
        command_address_word = 48'h0;
    end
    task automatic frame(input logic [47:0] cmd, input int n);
        @(posedge link_clk);
        cs_n <= 1'b0;
        cmd_load <= 1'b1;
        command_address_word <= cmd;
        @(posedge link_clk);
        cmd_load <= 1'b0;
        word_adv <= 1'b1;
        // The word is no longer valid, so it must not look like the last value.
        command_address_word <= ~cmd;
        for (int i = 0; i < n; i++) begin
            #1;
            seen[i] = word_addr;
            @(posedge link_clk);
        end
        word_adv <= 1'b0;
        cs_n <= 1'b1;
    endtask
endmodule

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the burst address sequencer.
// Assumes: Link clock runs freely so config writes can cross at any time.
// Notes:   Every wrap code is run from two starts, plus a linear burst.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bas_seq_pkg::*;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst, cfg_wr, cs_n, cmd_load, word_adv, cfg_busy, burst_active;
    logic [2:0]  cfg_wdata;
    logic [47:0] command_address_word;
    logic [22:0] word_addr;
    bas_cfg_t    burst_config_register;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 sys_clk = ~sys_clk;
    // Edges at 3 + 6k never meet the sys_clk edges at 2 + 4k, so the domains stay apart.
    always #3 link_clk = ~link_clk;
    bas_seq u_bas_seq (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .burst_config_register(burst_config_register), .cfg_busy(cfg_busy),
        .link_clk(link_clk), .cs_n(cs_n), .cmd_load(cmd_load),
        .command_address_word(command_address_word), .word_adv(word_adv),
        .word_addr(word_addr), .burst_active(burst_active));
    bas_host_model u_bas_host_model (.link_clk(link_clk), .word_addr(word_addr), .cs_n(cs_n),
        .cmd_load(cmd_load), .command_address_word(command_address_word), .word_adv(word_adv));
    task automatic check(input string what, input logic [22:0] seen, input logic [22:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [22:0] exp_addr(logic [2:0] m, logic bt, logic [22:0] s, int i);
        int gw;
        logic [22:0] base;
        gw = (m[1:0] == 2'h0) ? 64 : (m[1:0] == 2'h1) ? 32 : (m[1:0] == 2'h2) ? 8 : 16;
        base = s & ~23'(gw - 1);
        if (bt) return s + 23'(i);
        if (!m[2] && i >= gw) return base + 23'(gw) + 23'(i - gw);
        return base | ((s + 23'(i)) & 23'(gw - 1));
    endfunction
    task automatic set_cfg(input logic [2:0] m);
        @(posedge sys_clk);
        cfg_wr <= 1'b1;
        cfg_wdata <= m;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 40 && cfg_busy !== 1'b0; k++) @(posedge sys_clk);
        #1;
        check("cfg_busy", 23'(cfg_busy), 23'h0);
        check("config", 23'(burst_config_register), 23'(m));
    endtask
    task automatic run_burst(input logic [2:0] m, input logic bt, input logic [22:0] s);
        logic [47:0] cmd;
        logic [22:0] e;
        cmd = 48'h0;
        cmd[45] = bt;
        cmd[44:16] = 29'(s[22:3]);
        cmd[2:0] = s[2:0];
        u_bas_host_model.frame(cmd, 70);
        for (int i = 0; i < 70; i++) begin
            e = exp_addr(m, bt, s, i);
            check("word_addr", u_bas_host_model.seen[i], e);
        end
        #1;
        check("burst_active", 23'(burst_active), 23'h1);
        repeat (2) @(posedge link_clk);
        #1;
        check("burst_active", 23'(burst_active), 23'h0);
    endtask
    task automatic test_reset();
        check("reset config", 23'(burst_config_register), 23'h7);
        check("reset active", 23'(burst_active), 23'h0);
        check("reset word_addr", word_addr, 23'h0);
        $display("test_reset done");
    endtask
    task automatic test_modes();
        for (int m = 0; m < 8; m++) begin
            set_cfg(3'(m));
            run_burst(3'(m), 1'b0, 23'h04A2E);
            run_burst(3'(m), 1'b0, 23'h03F0C);
        end
        $display("test_modes done");
    endtask
    task automatic test_linear();
        set_cfg(3'h5);
        run_burst(3'h5, 1'b1, 23'h01203);
        $display("test_linear done");
    endtask
    // No write yet: the link side must run legacy 32-byte wrapping from its reset value.
    task automatic test_default();
        run_burst(3'h7, 1'b0, 23'h0001E);
        $display("test_default done");
    endtask
    // A second write while the first is still crossing must be dropped silently.
    task automatic test_busy();
        @(posedge sys_clk);
        cfg_wr <= 1'b1;
        cfg_wdata <= 3'h1;
        @(posedge sys_clk);
        cfg_wdata <= 3'h2;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        #1;
        check("busy flag", 23'(cfg_busy), 23'h1);
        check("busy config", 23'(burst_config_register), 23'h1);
        for (int k = 0; k < 40 && cfg_busy !== 1'b0; k++) @(posedge sys_clk);
        #1;
        check("busy cleared", 23'(cfg_busy), 23'h0);
        check("kept config", 23'(burst_config_register), 23'h1);
        run_burst(3'h1, 1'b0, 23'h04A2E);
        $display("test_busy done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_wdata = 3'h0;
        repeat (16) @(posedge sys_clk);
        test_reset();
        rst <= 1'b0;
        repeat (8) @(posedge link_clk);
        test_default();
        test_modes();
        test_busy();
        test_linear();
        give_verdict();
    end
endmodule
